// >>> rtl/pmbc_consts.vh
`ifndef PMBC_CONSTS_VH
`define PMBC_CONSTS_VH

// ****************************************
// Register addresses and PHY addresses
// ****************************************
`define PMBC_REGAD_CTRL 5'h00
`define PMBC_REGAD_STAT 5'h01
`define PMBC_PHYAD_P1 5'h01
`define PMBC_PHYAD_P2 5'h02
`define PMBC_PHYAD_STEP 5'h01

// ****************************************
// Basic control layout
// ****************************************
`define PMBC_CTRL_RST 16'h1020
`define PMBC_CTRL_WMASK 16'h7b3f
`define PMBC_CTRL_RAN_CLR 16'hfdff
`define PMBC_B_LOOP 14
`define PMBC_B_F100 13
`define PMBC_B_AN 12
`define PMBC_B_PDN 11
`define PMBC_B_RAN 9
`define PMBC_B_FDX 8
`define PMBC_B_XSCH 5
`define PMBC_B_FMDI 4
`define PMBC_B_NOMDIX 3
`define PMBC_B_NOFEF 2
`define PMBC_B_NOTX 1
`define PMBC_B_NOLED 0

// ****************************************
// Basic status layout
// ****************************************
`define PMBC_STAT_FIXED 16'h7808
`define PMBC_S_ANDONE 5
`define PMBC_S_FEF 4
`define PMBC_S_LINK 2

// ****************************************
// Management frame timing
// ****************************************
`define PMBC_PRE_LEN 6'h20
`define PMBC_OP_RD 2'h2
`define PMBC_OP_WR 2'h1
`define PMBC_HDR_LAST 4'hb
`define PMBC_TA_LAST 4'h1
`define PMBC_DATA_LAST 4'hf

`endif

// >>> rtl/pmbc_ctrl_reg.v
`include "pmbc_consts.vh"

module pmbc_ctrl_reg (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Management write
  input wire mii_wr,
  input wire [15:0] mii_data,
  // Mirror write from the switch's per-port register
  input wire alt_wr,
  input wire [15:0] alt_data,
  // Stored control word
  output reg [15:0] ctrl_q
);

  // ****************************************
  // Control word
  // ****************************************
  // Read-only positions are masked off on every write
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= `PMBC_CTRL_RST;
    end else if (mii_wr) begin
      ctrl_q <= mii_data & `PMBC_CTRL_WMASK;
    end else if (alt_wr) begin
      ctrl_q <= alt_data & `PMBC_CTRL_WMASK;
    end else begin
      // Restart request lasts one cycle, then reads back as normal operation
      ctrl_q <= ctrl_q & `PMBC_CTRL_RAN_CLR;
    end
  end

endmodule

// >>> rtl/pmbc_mii_regs.v
`include "pmbc_consts.vh"

module pmbc_mii_regs (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Management pins
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe_b,
  // PHY address programming from global control
  input wire phyad_prog_en,
  input wire [4:0] phyad_prog,
  // Mirror writes from the per-port switch registers
  input wire alt_wr_p1,
  input wire [15:0] alt_data_p1,
  input wire alt_wr_p2,
  input wire [15:0] alt_data_p2,
  // Live PHY state, bit 0 port 1, bit 1 port 2
  input wire [1:0] an_done,
  input wire [1:0] link_up,
  input wire [1:0] far_fault,
  // Loopback steering
  output wire wrap_p2_at_p1,
  output wire wrap_p1_at_p2,
  // Per-port PHY controls, bit 0 port 1, bit 1 port 2
  output wire [1:0] force_100,
  output wire [1:0] negotiation_on,
  output wire [1:0] power_down,
  output wire [1:0] renegotiate_link,
  output wire [1:0] force_full,
  output wire [1:0] crossover_scheme_select,
  output wire [1:0] force_straight_wiring,
  output wire [1:0] mdix_off,
  output wire [1:0] far_fault_off,
  output wire [1:0] tx_off,
  output wire [1:0] led_off,
  // Control words mirrored to the switch registers
  output wire [15:0] ctrl_p1,
  output wire [15:0] ctrl_p2
);

  // ****************************************
  // Frame states
  // ****************************************
  localparam [4:0] S_PRE = 5'h01;
  localparam [4:0] S_ST = 5'h02;
  localparam [4:0] S_HDR = 5'h04;
  localparam [4:0] S_TA = 5'h08;
  localparam [4:0] S_DATA = 5'h10;

  // ****************************************
  // Helpers
  // ****************************************
  function [15:0] status_word;
    input an_c;
    input link_c;
    input fef_c;
    reg [15:0] w;
    begin
      w = `PMBC_STAT_FIXED;
      w[`PMBC_S_ANDONE] = an_c;
      w[`PMBC_S_FEF] = fef_c;
      w[`PMBC_S_LINK] = link_c;
      status_word = w;
    end
  endfunction

  function reg_known;
    input [4:0] regad;
    begin
      reg_known = (regad == `PMBC_REGAD_CTRL) || (regad == `PMBC_REGAD_STAT);
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg mdc_s1_q;
  reg mdc_s2_q;
  reg mdc_s3_q;
  reg mdio_s1_q;
  reg mdio_s2_q;

  always @(posedge clk) begin
    if (!rst_b) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q <= mdc;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  // Both pins pass the same two stages, so data and clock stay aligned
  wire mdc_rise = mdc_s2_q & ~mdc_s3_q;
  wire bit_in = mdio_s2_q;

  // ****************************************
  // PHY addresses
  // ****************************************
  // One programmed base serves port 1; port 2 takes the next address
  wire [4:0] phyad_p1 = phyad_prog_en ? phyad_prog : `PMBC_PHYAD_P1;
  wire [4:0] phyad_p2 = phyad_prog_en ? (phyad_prog + `PMBC_PHYAD_STEP) :
                        `PMBC_PHYAD_P2;

  // ****************************************
  // Register words
  // ****************************************
  wire [15:0] ctrl_w1;
  wire [15:0] ctrl_w2;
  wire [15:0] stat_w1 = status_word(an_done[0], link_up[0], far_fault[0]);
  wire [15:0] stat_w2 = status_word(an_done[1], link_up[1], far_fault[1]);

  // ****************************************
  // Frame engine
  // ****************************************
  reg [4:0] st_q;
  reg [5:0] pre_cnt_q;
  reg [3:0] cnt_q;
  reg [10:0] hdr_q;
  reg [15:0] shift_q;
  reg rd_q;
  reg wr_q;
  reg port_q;
  reg reg_q;
  reg mdio_out_q;
  reg mdio_oe_b_q;
  reg [1:0] mii_wr_q;
  reg [15:0] mii_data_q;

  wire [11:0] hdr_full = {hdr_q, bit_in};
  wire [1:0] hdr_op = hdr_full[11:10];
  wire [4:0] hdr_phyad = hdr_full[9:5];
  wire [4:0] hdr_regad = hdr_full[4:0];
  wire hit_p1 = (hdr_phyad == phyad_p1) && reg_known(hdr_regad);
  wire hit_p2 = (hdr_phyad == phyad_p2) && reg_known(hdr_regad);
  wire [15:0] rd_word = port_q ? (reg_q ? stat_w2 : ctrl_w2) :
                        (reg_q ? stat_w1 : ctrl_w1);

  always @(posedge clk) begin
    if (!rst_b) begin
      st_q <= S_PRE;
      pre_cnt_q <= 6'h00;
      cnt_q <= 4'h0;
      hdr_q <= 11'h000;
      shift_q <= 16'h0000;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      port_q <= 1'b0;
      reg_q <= 1'b0;
      mdio_out_q <= 1'b1;
      mdio_oe_b_q <= 1'b1;
      mii_wr_q <= 2'h0;
      mii_data_q <= 16'h0000;
    end else begin
      mii_wr_q <= 2'h0;
      if (mdc_rise) begin
        case (st_q)
          S_PRE: begin
            if (bit_in) begin
              if (pre_cnt_q != `PMBC_PRE_LEN) begin
                pre_cnt_q <= pre_cnt_q + 6'h01;
              end
            end else begin
              pre_cnt_q <= 6'h00;
              if (pre_cnt_q == `PMBC_PRE_LEN) begin
                st_q <= S_ST;
              end
            end
          end
          S_ST: begin
            cnt_q <= 4'h0;
            st_q <= bit_in ? S_HDR : S_PRE;
          end
          S_HDR: begin
            hdr_q <= hdr_full[10:0];
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `PMBC_HDR_LAST) begin
              cnt_q <= 4'h0;
              // Another block answers addresses that miss this pair
              rd_q <= (hdr_op == `PMBC_OP_RD) && (hit_p1 || hit_p2);
              wr_q <= (hdr_op == `PMBC_OP_WR) && (hit_p1 || hit_p2);
              port_q <= hit_p2 && !hit_p1;
              reg_q <= (hdr_regad == `PMBC_REGAD_STAT);
              st_q <= S_TA;
            end
          end
          S_TA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q != `PMBC_TA_LAST) begin
              if (rd_q) begin
                mdio_out_q <= 1'b0;
                mdio_oe_b_q <= 1'b0;
              end
            end else begin
              cnt_q <= 4'h0;
              st_q <= S_DATA;
              if (rd_q) begin
                shift_q <= rd_word;
                mdio_out_q <= rd_word[15];
              end
            end
          end
          S_DATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (rd_q) begin
              shift_q <= {shift_q[14:0], 1'b0};
              mdio_out_q <= shift_q[14];
            end else begin
              shift_q <= {shift_q[14:0], bit_in};
            end
            if (cnt_q == `PMBC_DATA_LAST) begin
              cnt_q <= 4'h0;
              mdio_oe_b_q <= 1'b1;
              mdio_out_q <= 1'b1;
              st_q <= S_PRE;
              // Status is read-only; only the control word takes writes
              if (wr_q && !reg_q) begin
                mii_data_q <= {shift_q[14:0], bit_in};
                mii_wr_q <= port_q ? 2'h2 : 2'h1;
              end
            end
          end
          default: begin
            st_q <= S_PRE;
            pre_cnt_q <= 6'h00;
            mdio_oe_b_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign mdio_out = mdio_out_q;
  assign mdio_oe_b = mdio_oe_b_q;

  // ****************************************
  // Per-port control words
  // ****************************************
  pmbc_ctrl_reg u_ctrl_p1 (
    .clk(clk),
    .rst_b(rst_b),
    .mii_wr(mii_wr_q[0]),
    .mii_data(mii_data_q),
    .alt_wr(alt_wr_p1),
    .alt_data(alt_data_p1),
    .ctrl_q(ctrl_w1)
  );

  pmbc_ctrl_reg u_ctrl_p2 (
    .clk(clk),
    .rst_b(rst_b),
    .mii_wr(mii_wr_q[1]),
    .mii_data(mii_data_q),
    .alt_wr(alt_wr_p2),
    .alt_data(alt_data_p2),
    .ctrl_q(ctrl_w2)
  );

  // ****************************************
  // Control outputs
  // ****************************************
  // Speed is not checked here; loopback at 10 Mbps is the station's fault
  assign wrap_p2_at_p1 = ctrl_w1[`PMBC_B_LOOP];
  assign wrap_p1_at_p2 = ctrl_w2[`PMBC_B_LOOP];
  assign force_100 = {ctrl_w2[`PMBC_B_F100], ctrl_w1[`PMBC_B_F100]};
  assign negotiation_on = {ctrl_w2[`PMBC_B_AN], ctrl_w1[`PMBC_B_AN]};
  assign power_down = {ctrl_w2[`PMBC_B_PDN], ctrl_w1[`PMBC_B_PDN]};
  assign renegotiate_link = {ctrl_w2[`PMBC_B_RAN], ctrl_w1[`PMBC_B_RAN]};
  assign force_full = {ctrl_w2[`PMBC_B_FDX], ctrl_w1[`PMBC_B_FDX]};
  assign crossover_scheme_select = {ctrl_w2[`PMBC_B_XSCH], ctrl_w1[`PMBC_B_XSCH]};
  assign force_straight_wiring = {ctrl_w2[`PMBC_B_FMDI], ctrl_w1[`PMBC_B_FMDI]};
  assign mdix_off = {ctrl_w2[`PMBC_B_NOMDIX], ctrl_w1[`PMBC_B_NOMDIX]};
  assign far_fault_off = {ctrl_w2[`PMBC_B_NOFEF], ctrl_w1[`PMBC_B_NOFEF]};
  assign tx_off = {ctrl_w2[`PMBC_B_NOTX], ctrl_w1[`PMBC_B_NOTX]};
  assign led_off = {ctrl_w2[`PMBC_B_NOLED], ctrl_w1[`PMBC_B_NOLED]};
  assign ctrl_p1 = ctrl_w1;
  assign ctrl_p2 = ctrl_w2;

endmodule

// >>> verification/pmbc_mii_regs_asserts.sv
// ****************************************
// Port checker
// ****************************************
module pmbc_mii_regs_asserts (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Management pin
  input wire mdio_out,
  input wire mdio_oe_b,
  // Mirror write
  input wire alt_wr_p1,
  input wire [15:0] alt_data_p1,
  // Controls
  input wire wrap_p2_at_p1,
  input wire wrap_p1_at_p2,
  input wire [1:0] negotiation_on,
  input wire [1:0] renegotiate_link,
  input wire [1:0] crossover_scheme_select,
  input wire [1:0] force_straight_wiring,
  input wire [1:0] mdix_off,
  input wire [1:0] far_fault_off,
  input wire [1:0] tx_off,
  input wire [15:0] ctrl_p1,
  input wire [15:0] ctrl_p2
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_rst;
    disable iff (1'b0) !rst_b |=> ctrl_p1 == 16'h1020 && ctrl_p2 == 16'h1020 && mdio_oe_b;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset word");
  property p_loop;
    {wrap_p1_at_p2, wrap_p2_at_p1} == {ctrl_p2[14], ctrl_p1[14]};
  endproperty
  a_loop: assert property (p_loop) else $error("loopback steer");
  property p_an;
    negotiation_on == {ctrl_p2[12], ctrl_p1[12]};
  endproperty
  a_an: assert property (p_an) else $error("negotiation out");
  property p_ro;
    ((ctrl_p1 | ctrl_p2) & 16'h84c0) == 16'h0;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only bit set");
  property p_ran;
    renegotiate_link != 2'h0 |=> renegotiate_link == 2'h0;
  endproperty
  a_ran: assert property (p_ran) else $error("renegotiate not a pulse");
  property p_xs;
    crossover_scheme_select == {ctrl_p2[5], ctrl_p1[5]};
  endproperty
  a_xs: assert property (p_xs) else $error("crossover scheme");
  property p_phy;
    {force_straight_wiring, mdix_off, far_fault_off, tx_off} == {ctrl_p2[4], ctrl_p1[4],
      ctrl_p2[3], ctrl_p1[3], ctrl_p2[2], ctrl_p1[2], ctrl_p2[1], ctrl_p1[1]};
  endproperty
  a_phy: assert property (p_phy) else $error("phy controls");
  property p_mir;
    alt_wr_p1 |=> (ctrl_p1 & 16'h793f) == ($past(alt_data_p1) & 16'h793f);
  endproperty
  a_mir: assert property (p_mir) else $error("mirror write");
  property p_ta;
    $fell(mdio_oe_b) |-> !mdio_out ##1 (!mdio_oe_b) [*8];
  endproperty
  a_ta: assert property (p_ta) else $error("read turnaround");
  cover property ($fell(mdio_oe_b));
  cover property (renegotiate_link[0]);
  cover property ($rose(wrap_p2_at_p1));
endmodule
bind pmbc_mii_regs pmbc_mii_regs_asserts pmbc_mii_regs_asserts_i (.clk(clk), .rst_b(rst_b),
  .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b), .alt_wr_p1(alt_wr_p1),
  .alt_data_p1(alt_data_p1), .wrap_p2_at_p1(wrap_p2_at_p1), .wrap_p1_at_p2(wrap_p1_at_p2),
  .negotiation_on(negotiation_on), .renegotiate_link(renegotiate_link),
  .crossover_scheme_select(crossover_scheme_select), .mdix_off(mdix_off),
  .force_straight_wiring(force_straight_wiring), .far_fault_off(far_fault_off),
  .tx_off(tx_off), .ctrl_p1(ctrl_p1), .ctrl_p2(ctrl_p2));

// >>> verification/pmbc_mii_regs_bench.sv
module pmbc_mii_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, mdc, mdio_in, mdio_out, mdio_oe_b, rd_v, phyad_prog_en;
  logic alt_wr_p1, alt_wr_p2, wrap_p2_at_p1, wrap_p1_at_p2;
  logic [1:0] an_done, link_up, far_fault;
  logic [1:0] force_100, power_down, force_full, led_off, renegotiate_link, ran_seen;
  logic [4:0] phyad_prog, pa;
  logic [15:0] alt_data_p1, alt_data_p2, rd_w, wd;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int num_errors = 0;
  int n_tests = 0;
  pmbc_mii_regs pmbc_mii_regs_i (.clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b), .phyad_prog_en(phyad_prog_en),
    .phyad_prog(phyad_prog), .alt_wr_p1(alt_wr_p1), .alt_data_p1(alt_data_p1),
    .alt_wr_p2(alt_wr_p2), .alt_data_p2(alt_data_p2), .an_done(an_done),
    .link_up(link_up), .far_fault(far_fault), .wrap_p2_at_p1(wrap_p2_at_p1),
    .wrap_p1_at_p2(wrap_p1_at_p2), .force_100(force_100), .negotiation_on(),
    .power_down(power_down), .renegotiate_link(renegotiate_link),
    .force_full(force_full), .crossover_scheme_select(),
    .force_straight_wiring(), .mdix_off(), .far_fault_off(), .tx_off(), .led_off(led_off),
    .ctrl_p1(), .ctrl_p2());
  pmbc_station pmbc_station_i (.clk(clk), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b), .rd_v(rd_v), .rd_w(rd_w));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] stat(input int p);
    return 16'h7808 | {10'h0, an_done[p], far_fault[p], 1'b0, link_up[p], 2'h0};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [4:0] r, input logic [15:0] e);
    exp_q.push_back(e);
    pmbc_station_i.frame(2'h2, a, r, 16'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic reset;
    @(posedge clk) #5 rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #5 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #5;
  endtask
  // Oldest note is matched against each read result
  always @(posedge clk) begin
    if (rd_v === 1'b1) chk(rd_w, exp_q.pop_front());
    // Restart pulse lasts one cycle, so it is caught here and cleared by each read
    ran_seen <= (!rst_b || rd_v) ? 2'h0 : (ran_seen | renegotiate_link);
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    test_done;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {rst_b, phyad_prog_en, phyad_prog, alt_wr_p1, alt_wr_p2} = 9'h0;
    {alt_data_p1, alt_data_p2} = 32'h0;
    seed = 32'h5348;
    {an_done, link_up, far_fault} = seed[5:0];
    reset;
    rd(5'h01, 5'h00, 16'h1020);
    rd(5'h02, 5'h00, 16'h1020);
    rd(5'h01, 5'h01, stat(0));
    rd(5'h02, 5'h01, stat(1));
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wd = (i == 0) ? 16'hffff : seed[15:0];
      wd[13] = wd[13] | wd[14];
      pa = i[0] ? 5'h02 : 5'h01;
      pmbc_station_i.frame(2'h1, pa, 5'h00, wd);
      chk({15'h0, i[0] ? wrap_p1_at_p2 : wrap_p2_at_p1}, {15'h0, wd[14]});
      chk({14'h0, ran_seen}, {14'h0, i[0] ? {wd[9], 1'b0} : {1'b0, wd[9]}});
      chk({12'h0, force_100[i[0]], power_down[i[0]], force_full[i[0]], led_off[i[0]]},
        {12'h0, wd[13], wd[11], wd[8], wd[0]});
      rd(pa, 5'h00, wd & 16'h793f);
    end
    $display("test write done");
    // Flip every live status input so each bit is seen both ways
    {an_done, link_up, far_fault} = ~{an_done, link_up, far_fault};
    pmbc_station_i.frame(2'h1, 5'h01, 5'h01, 16'h0);
    rd(5'h01, 5'h01, stat(0));
    rd(5'h02, 5'h01, stat(1));
    rd(5'h01, 5'h03, 16'hffff);
    rd(5'h05, 5'h00, 16'hffff);
    $display("test refuse done");
    seed = lfsr(seed);
    alt_data_p1 = seed[15:0] | 16'h6200;
    alt_data_p2 = seed[31:16] | 16'h6000;
    {alt_wr_p1, alt_wr_p2} = 2'h3;
    @(posedge clk) #5 {alt_wr_p1, alt_wr_p2} = 2'h0;
    @(posedge clk) #5;
    chk({14'h0, wrap_p1_at_p2, wrap_p2_at_p1}, 16'h3);
    rd(5'h01, 5'h00, alt_data_p1 & 16'h793f);
    rd(5'h02, 5'h00, alt_data_p2 & 16'h793f);
    $display("test mirror done");
    phyad_prog = 5'h1f;
    phyad_prog_en = 1'b1;
    pmbc_station_i.frame(2'h1, 5'h00, 5'h00, 16'h0);
    rd(5'h00, 5'h00, 16'h0);
    rd(5'h1f, 5'h01, stat(0));
    rd(5'h02, 5'h00, 16'hffff);
    reset;
    rd(5'h00, 5'h00, 16'h1020);
    $display("test address done");
    chk(16'(exp_q.size()), 16'h0);
    test_done;
  end
endmodule

// >>> verification/pmbc_station.sv
// ****************************************
// Management station model
// ****************************************
module pmbc_station (
  // Clock
  input wire logic clk,
  // Management pins
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_b,
  // Read result
  output logic rd_v,
  output logic [15:0] rd_w
);
  timeunit 1ns;
  timeprecision 1ns;
  logic st_q;
  // Released line floats to the pull-up level
  assign mdio_in = mdio_oe_b ? st_q : mdio_out;
  initial begin
    mdc = 1'b0;
    st_q = 1'b1;
    rd_v = 1'b0;
    rd_w = 16'h0;
  end
  // MDC stands low between frames; reads release TA and data
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd);
    logic [63:0] sh;
    sh = {32'hffffffff, 2'b01, op, pa, ra, (op == 2'h1) ? {2'b10, wd} : 18'h3ffff};
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk) #5;
      mdc = 1'b0;
      st_q = sh[i];
      repeat (4) @(posedge clk);
      #5 rd_w = {rd_w[14:0], mdio_in};
      mdc = 1'b1;
      repeat (4) @(posedge clk);
    end
    @(posedge clk) #5;
    mdc = 1'b0;
    st_q = 1'b1;
    rd_v = (op == 2'h2);
    @(posedge clk) #5 rd_v = 1'b0;
  endtask
endmodule
